/* File: bench/irsm_core_model.sv */
`default_nettype none
module irsm_core_model
  import irsm_pkg::*;
(
  // working register lookup
  input wire logic [7:0] work_reg_addr,
  output logic [7:0] reg_value
);
  logic [7:0] ram_mem [256];
  // each byte holds its inverted address, so a pointer is traceable
  initial begin
    for (int i = 0; i < 256; i++) begin
      ram_mem[i] = ~8'(i);
    end
  end
  assign reg_value = ram_mem[work_reg_addr];
endmodule : irsm_core_model
`default_nettype wire

/* File: bench/irsm_map_assertions.sv */
`default_nettype none
module irsm_map_chk
  import irsm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // requests seen by the block
  input wire logic acc_valid,
  input wire logic acc_indirect,
  input wire logic acc_bit,
  input wire logic acc_use_reg,
  input wire logic [2:0] acc_reg_sel,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] reg_value,
  input wire logic [7:0] psw_value,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [1:0] stk_count,
  // decode and pointer results
  input wire logic [7:0] ram_addr,
  input wire logic ram_sel,
  input wire logic sfr_sel,
  input wire logic [2:0] bit_pos,
  input wire logic [7:0] work_reg_addr,
  input wire logic [9:0] stack_addr,
  input wire logic stack_in_sram,
  input wire logic [7:0] stack_pointer_low,
  input wire logic [1:0] stack_pointer_extension,
  input wire logic large_stack_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // plain direct byte access and the joined 10-bit pointer
  logic dir;
  logic [9:0] ptr10;
  assign dir = acc_valid & ~acc_indirect & ~acc_bit & ~acc_use_reg;
  assign ptr10 = {stack_pointer_extension, stack_pointer_low};
  sequence s_push;
    stk_push && !large_stack_enable;
  endsequence
  sequence s_pop;
    stk_pop && !stk_push && !large_stack_enable;
  endsequence
  a_direct_split: assert property (
    dir |-> ram_sel != acc_addr[7] && sfr_sel == acc_addr[7]
    && (acc_addr[7] || ram_addr == acc_addr)) else $error("direct decode");
  a_indirect_ptr: assert property (
    acc_valid && acc_indirect && acc_use_reg |-> ram_sel
    && ram_addr == reg_value) else $error("indirect pointer");
  a_bank_select: assert property (
    acc_valid && acc_use_reg |-> work_reg_addr ==
    {3'h0, psw_value[4:3], acc_reg_sel}) else $error("bank select");
  a_ram_bit: assert property (
    acc_valid && acc_bit && !acc_addr[7] |-> ram_addr ==
    {4'h2, acc_addr[6:3]} && bit_pos == acc_addr[2:0]) else $error("ram bit");
  a_sfr_bit: assert property (
    acc_valid && acc_bit && acc_addr[7] |-> sfr_sel && !ram_sel
    && bit_pos == acc_addr[2:0]) else $error("sfr bit");
  a_reset_pointer: assert property (
    $rose(reset_n) |-> stack_pointer_low == 8'h07 && !large_stack_enable)
    else $error("pointer reset value");
  a_push_step: assert property (
    s_push |-> stack_addr[7:0] == 8'(stack_pointer_low + stk_count) ##1
    stack_pointer_low == 8'($past(stack_pointer_low) + $past(stk_count)))
    else $error("push step");
  a_pop_step: assert property (
    s_pop |=> stack_pointer_low ==
    8'($past(stack_pointer_low) - $past(stk_count))) else $error("pop step");
  a_large_carry: assert property (
    large_stack_enable && stk_push |=> ptr10 ==
    10'($past(ptr10) + $past(stk_count))) else $error("large carry");
  a_large_addr: assert property (
    large_stack_enable && !stk_push && !stk_pop |-> stack_in_sram
    && stack_addr == ptr10) else $error("large stack address");
endmodule : irsm_map_chk
`default_nettype wire

/* File: bench/irsm_map_tb.sv */
`default_nettype none
module irsm_map_tb
  import irsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset_n = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
  logic acc_indirect = 1'b0, acc_bit = 1'b0, acc_use_reg = 1'b0;
  logic stk_push = 1'b0, stk_pop = 1'b0, code_fetch = 1'b0;
  logic code_table_read_instr = 1'b0, external_data_move_instr = 1'b0;
  logic [2:0] acc_reg_sel = 3'h0, acc_bit_sel = 3'h0;
  logic [1:0] stk_count = 2'h0;
  logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, reg_value;
  logic [7:0] mcon_value = 8'h00, psw_value = 8'h00;
  logic [21:0] code_req_addr = 22'h0, data_req_addr = 22'h0;
  logic [7:0] ram_addr, sfr_rdata, work_reg_addr, stack_pointer_low;
  logic ram_sel, sfr_sel, bit_access_ok, sfr_hit, stack_in_sram, code_rd;
  logic large_stack_enable, large_stack_illegal, data_en;
  logic [2:0] bit_pos;
  logic [9:0] stack_addr;
  logic [1:0] stack_pointer_extension;
  logic [19:0] code_addr, data_addr;
  logic [3:0] code_ce, data_ce;
  int error_cnt = 0, checks = 0, cyc = 0;
  irsm_map i_irsm_map (.clock, .reset_n, .acc_valid, .acc_write,
    .acc_indirect, .acc_bit, .acc_reg_sel, .acc_use_reg, .acc_addr,
    .acc_bit_sel, .acc_wdata, .reg_value, .stk_push, .stk_pop, .stk_count,
    .mcon_value, .psw_value, .code_fetch, .code_table_read_instr,
    .external_data_move_instr, .code_req_addr, .data_req_addr, .ram_addr,
    .ram_sel, .sfr_sel, .bit_access_ok, .bit_pos, .sfr_rdata, .sfr_hit,
    .work_reg_addr, .stack_addr, .stack_in_sram, .stack_pointer_low,
    .stack_pointer_extension, .large_stack_enable, .large_stack_illegal,
    .code_addr, .code_ce, .code_rd, .data_addr, .data_ce, .data_en);
  irsm_core_model i_irsm_core_model (.work_reg_addr, .reg_value);
  always #5 clock = ~clock;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // k is {write, indirect, bit, use_reg}; waits until decode settles
  task automatic req(input logic [3:0] k, input logic [2:0] sel,
                     input logic [7:0] adr, wd);
    @(posedge clock);
    acc_valid <= 1'b1;
    {acc_write, acc_indirect, acc_bit, acc_use_reg} <= k;
    acc_reg_sel <= sel;
    acc_addr <= adr;
    acc_wdata <= wd;
    @(negedge clock);
  endtask : req
  // release at the taking edge, so a read answer is visible on return
  task automatic fin();
    @(posedge clock);
    acc_valid <= 1'b0;
    @(negedge clock);
  endtask : fin
  task automatic wr_reg(input logic [7:0] adr, wd);
    req(4'h8, 3'h0, adr, wd);
    fin();
  endtask : wr_reg
  task automatic rd_hit(input logic [7:0] adr, output logic [15:0] got);
    req(4'h0, 3'h0, adr, 8'h00);
    fin();
    got = {7'h00, sfr_hit, sfr_rdata};
  endtask : rd_hit
  // stack ops run back to back; the next call's edge takes this one
  task automatic stk(input logic [1:0] op, cnt);
    @(posedge clock);
    {stk_push, stk_pop} <= op;
    stk_count <= cnt;
    @(negedge clock);
  endtask : stk
  logic [7:0] dir_tab [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  logic [15:0] got;
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    rd_hit(IRSM_SP_ADDR, got);
    chk("sp reset", got, 16'h0107);
    rd_hit(IRSM_ESP_ADDR, got);
    chk("esp reset", got, 16'h01FC);
    rd_hit(IRSM_ADDRESS_CONTROL_REGISTER_ADDR, got);
    chk("address_control_register reset", got, 16'h01F8);
    // both ends of each half of the direct space; none is ours to answer
    foreach (dir_tab[i]) begin
      req(4'h0, 3'h0, dir_tab[i], 8'h00);
      chk("ram_sel", 16'(ram_sel), 16'(!dir_tab[i][7]));
      chk("sfr_sel", 16'(sfr_sel), 16'(dir_tab[i][7]));
      fin();
      chk("unmapped hit", 16'(sfr_hit), 16'h0000);
    end
    @(posedge clock) psw_value <= 8'h10;
    req(4'h5, 3'h1, 8'h00, 8'h00);
    chk("bank reg", 16'(work_reg_addr), 16'h0011);
    chk("indirect", 16'({ram_sel, ram_addr}), 16'h01EE);
    req(4'h2, 3'h0, 8'h2B, 8'h00);
    chk("ram bit", 16'({ram_sel, bit_pos, ram_addr}), 16'h0B25);
    req(4'h2, 3'h0, 8'hD3, 8'h00);
    chk("sfr bit", 16'({sfr_sel, bit_access_ok, bit_pos}), 16'h001B);
    fin();
    wr_reg(IRSM_SP_ADDR, 8'hFF);
    stk(2'b10, 2'h1);
    chk("push addr", 16'(stack_addr[7:0]), 16'h0000);
    stk(2'b01, 2'h2);
    chk("sp wrap", 16'(stack_pointer_low), 16'h0000);
    stk(2'b00, 2'h0);
    chk("sp pop", 16'(stack_pointer_low), 16'h00FE);
    wr_reg(IRSM_ADDRESS_CONTROL_REGISTER_ADDR, 8'h04);
    wr_reg(IRSM_ESP_ADDR, 8'h01);
    wr_reg(IRSM_SP_ADDR, 8'hFF);
    stk(2'b10, 2'h1);
    chk("large push", 16'({stack_in_sram, stack_addr}), 16'h0600);
    stk(2'b00, 2'h0);
    rd_hit(IRSM_ESP_ADDR, got);
    chk("esp carry", got, 16'h01FE);
    stk(2'b01, 2'h1);
    stk(2'b00, 2'h0);
    chk("borrow", 16'({stack_pointer_extension, stack_pointer_low}),
        16'h01FF);
    // large stack with combined memory use is flagged
    @(posedge clock) mcon_value <= 8'hC0;
    @(negedge clock) chk("illegal", 16'(large_stack_illegal), 16'h1);
    // fetch, table read, data move, then nothing
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      {code_fetch, code_table_read_instr, external_data_move_instr}
        <= 3'(3'h4 >> k);
      code_req_addr <= {2'(k), 20'hABCDE};
      data_req_addr <= {2'(k), 20'h12345};
      @(negedge clock);
      chk("code_rd", 16'(code_rd), 16'(k < 2));
      chk("data_en", 16'(data_en), 16'(k == 2));
      if (k < 2) begin
        chk("code bus", 16'({code_ce, code_addr[11:0]}),
            16'({4'h1 << k, 12'hCDE}));
      end
      if (k == 2) begin
        chk("data bus", 16'({data_ce, data_addr[11:0]}), 16'h4345);
      end
    end
    end_of_test();
  end
endmodule : irsm_map_tb
bind irsm_map irsm_map_chk i_irsm_map_chk (.clock, .reset_n, .acc_valid,
  .acc_indirect, .acc_bit, .acc_use_reg, .acc_reg_sel, .acc_addr,
  .reg_value, .psw_value, .stk_push, .stk_pop, .stk_count, .ram_addr,
  .ram_sel, .sfr_sel, .bit_pos, .work_reg_addr, .stack_addr, .stack_in_sram,
  .stack_pointer_low, .stack_pointer_extension, .large_stack_enable);
`default_nettype wire

/* File: include/irsm_pkg.sv */
`default_nettype none
package irsm_pkg;
  // register space boundaries
  localparam logic [7:0] IRSM_DIRECT_RAM_TOP = 8'h7F;
  localparam logic [7:0] IRSM_BIT_RAM_LO = 8'h20;
  localparam logic [7:0] IRSM_BIT_RAM_HI = 8'h2F;
  localparam logic [7:0] IRSM_BIT_RAM_BASE = 8'h20;
  localparam logic [3:0] IRSM_SFR_BIT_NIB = 4'h0;
  localparam logic [2:0] IRSM_SFR_BIT_LOW3 = 3'h0;
  // sfr offsets
  localparam logic [7:0] IRSM_SP_ADDR = 8'h81;
  localparam logic [7:0] IRSM_ESP_ADDR = 8'h9B;
  localparam logic [7:0] IRSM_ADDRESS_CONTROL_REGISTER_ADDR = 8'h9D;
  localparam logic [7:0] IRSM_MCON_ADDR = 8'hC6;
  localparam logic [7:0] IRSM_PSW_ADDR = 8'hD0;
  // reset values
  localparam logic [7:0] IRSM_SP_RESET = 8'h07;
  localparam logic [1:0] IRSM_ESP_RESET = 2'h0;
  localparam logic [2:0] IRSM_ADDRESS_CONTROL_REGISTER_RESET = 3'h0;
  localparam logic [7:0] IRSM_ESP_RD_FILL = 8'hFC;
  localparam logic [7:0] IRSM_ADDRESS_CONTROL_REGISTER_RD_FILL = 8'hF8;
  localparam logic [7:0] IRSM_PSW_RESET = 8'h00;
  localparam logic [1:0] IRSM_IDM_RESET = 2'h0;
  // field positions
  localparam int IRSM_ADDRESS_CONTROL_REGISTER_SA_BIT = 2;
  localparam int IRSM_PSW_RS0_BIT = 3;
  localparam int IRSM_MCON_INTERNAL_MEM_CONFIG_LO_BIT = 6;
  localparam logic [1:0] IRSM_IDM_COMBINED = 2'h3;
  // large stack base per memory configuration, in 1 KB units
  localparam logic [1:0] IRSM_STK_BASE_0 = 2'h0;
  localparam logic [1:0] IRSM_STK_BASE_1 = 2'h0;
  localparam logic [1:0] IRSM_STK_BASE_2 = 2'h0;
  localparam logic [1:0] IRSM_STK_BASE_3 = 2'h0;
  // access targets
  typedef enum logic [1:0] {
    IRSM_TGT_RAM = 2'b00,
    IRSM_TGT_SFR = 2'b01,
    IRSM_TGT_SRAM = 2'b11
  } irsm_tgt_t;
endpackage : irsm_pkg
`default_nettype wire

/* File: rtl/irsm_map.sv */
`default_nettype none
module irsm_map
  import irsm_pkg::*;
#(
  parameter int CODE_AW = 20,
  parameter int CE_W = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register access request from the core
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_indirect,
  input wire logic acc_bit,
  input wire logic [2:0] acc_reg_sel,
  input wire logic acc_use_reg,
  input wire logic [7:0] acc_addr,
  input wire logic [2:0] acc_bit_sel,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] reg_value,
  // stack operation request
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [1:0] stk_count,
  // memory configuration and status word copies
  input wire logic [7:0] mcon_value,
  input wire logic [7:0] psw_value,
  // external memory requests
  input wire logic code_fetch,
  input wire logic code_table_read_instr,
  input wire logic external_data_move_instr,
  input wire logic [CODE_AW+1:0] code_req_addr,
  input wire logic [CODE_AW+1:0] data_req_addr,
  // decoded register access
  output logic [7:0] ram_addr,
  output logic ram_sel,
  output logic sfr_sel,
  output logic bit_access_ok,
  output logic [2:0] bit_pos,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // working register pointer address
  output logic [7:0] work_reg_addr,
  // stack memory address
  output logic [9:0] stack_addr,
  output logic stack_in_sram,
  output logic [7:0] stack_pointer_low,
  output logic [1:0] stack_pointer_extension,
  output logic large_stack_enable,
  output logic large_stack_illegal,
  // external memory buses
  output logic [CODE_AW-1:0] code_addr,
  output logic [CE_W-1:0] code_ce,
  output logic code_rd,
  output logic [CODE_AW-1:0] data_addr,
  output logic [CE_W-1:0] data_ce,
  output logic data_en
);
  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  logic [7:0] sp_reg, sp_next;
  logic [1:0] esp_reg, esp_next;
  logic sa_reg, sa_next;
  logic [7:0] sfr_rdata_reg, sfr_rdata_next;
  logic sfr_hit_reg, sfr_hit_next;
  logic [9:0] stk_ptr, stk_step, stk_sum;
  logic [1:0] idm;
  logic [1:0] bank;
  logic [1:0] stk_base;
  logic [7:0] eff_addr;
  logic direct_sfr;

  assign idm = mcon_value[IRSM_MCON_INTERNAL_MEM_CONFIG_LO_BIT+1:IRSM_MCON_INTERNAL_MEM_CONFIG_LO_BIT];
  assign bank = psw_value[IRSM_PSW_RS0_BIT+1:IRSM_PSW_RS0_BIT];

  // ---------------------------------------------------------------
  // working registers and address decode
  // ---------------------------------------------------------------
  // working register location inside the selected bank
  always_comb begin
    work_reg_addr = {3'h0, bank, acc_reg_sel};
  end

  // pick the address: indirect through a working register value
  always_comb begin
    eff_addr = acc_addr;
    if (acc_indirect && acc_use_reg) begin
      eff_addr = reg_value;
    end else if (!acc_indirect && acc_use_reg) begin
      eff_addr = work_reg_addr;
    end
  end

  // direct references above 7Fh never land in upper RAM
  always_comb begin
    direct_sfr = !acc_indirect && (eff_addr > IRSM_DIRECT_RAM_TOP);
    ram_sel = acc_valid && !direct_sfr;
    sfr_sel = acc_valid && direct_sfr;
    ram_addr = eff_addr;
    bit_pos = acc_bit_sel;
    bit_access_ok = 1'b0;
    if (acc_bit) begin
      // bit number in acc_addr maps to a byte and bit position
      if (acc_addr <= IRSM_DIRECT_RAM_TOP) begin
        ram_addr = IRSM_BIT_RAM_BASE + {4'h0, acc_addr[6:3]};
        bit_pos = acc_addr[2:0];
        ram_sel = acc_valid;
        sfr_sel = 1'b0;
        bit_access_ok = (ram_addr >= IRSM_BIT_RAM_LO) &&
                        (ram_addr <= IRSM_BIT_RAM_HI);
      end else begin
        ram_addr = {acc_addr[7:3], IRSM_SFR_BIT_LOW3};
        bit_pos = acc_addr[2:0];
        ram_sel = 1'b0;
        sfr_sel = acc_valid;
        bit_access_ok = (ram_addr[2:0] == IRSM_SFR_BIT_LOW3) &&
                        (ram_addr[3:0] == IRSM_SFR_BIT_NIB ||
                         ram_addr[3] == 1'b1);
      end
    end
  end

  // ---------------------------------------------------------------
  // stack pointer logic
  // ---------------------------------------------------------------
  // full pointer; the extension only counts in large-stack mode.
  // a push and a pop in one cycle: the push wins, the pop is lost,
  // so the core must never issue both together.
  // in small-stack mode the pointer wraps within eight bits and the
  // extension keeps whatever software last wrote into it.
  always_comb begin
    stk_ptr = sa_reg ? {esp_reg, sp_reg} : {2'h0, sp_reg};
    stk_step = {8'h00, stk_count};
    stk_sum = stk_ptr;
    if (stk_push) begin
      stk_sum = stk_ptr + stk_step;
    end else if (stk_pop) begin
      stk_sum = stk_ptr - stk_step;
    end
  end

  // stack moves, or else sfr writes, drive the next pointer
  always_comb begin
    sp_next = sp_reg;
    esp_next = esp_reg;
    sa_next = sa_reg;
    if (stk_push || stk_pop) begin
      sp_next = stk_sum[7:0];
      if (sa_reg) begin
        esp_next = stk_sum[9:8];
      end
    end else if (sfr_sel && acc_write && !acc_bit) begin
      unique case (ram_addr)
        IRSM_SP_ADDR: sp_next = acc_wdata;
        IRSM_ESP_ADDR: esp_next = acc_wdata[1:0];
        IRSM_ADDRESS_CONTROL_REGISTER_ADDR: sa_next = acc_wdata[IRSM_ADDRESS_CONTROL_REGISTER_SA_BIT];
        default: ;
      endcase
    end else if (sfr_sel && acc_write && acc_bit && bit_access_ok) begin
      // only bit-addressable locations here; none of ours qualify
      sp_next = sp_reg;
    end
  end

  // read port for the sfrs this block owns
  always_comb begin
    sfr_rdata_next = 8'h00;
    sfr_hit_next = 1'b0;
    if (sfr_sel && !acc_write) begin
      unique case (ram_addr)
        IRSM_SP_ADDR: begin
          sfr_rdata_next = sp_reg;
          sfr_hit_next = 1'b1;
        end
        IRSM_ESP_ADDR: begin
          sfr_rdata_next = IRSM_ESP_RD_FILL | {6'h00, esp_reg};
          sfr_hit_next = 1'b1;
        end
        IRSM_ADDRESS_CONTROL_REGISTER_ADDR: begin
          sfr_rdata_next = IRSM_ADDRESS_CONTROL_REGISTER_RD_FILL |
                           {5'h00, sa_reg, 2'h0};
          sfr_hit_next = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // registers; reset only takes constants
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sp_reg <= IRSM_SP_RESET;
      esp_reg <= IRSM_ESP_RESET;
      sa_reg <= 1'b0;
      sfr_rdata_reg <= 8'h00;
      sfr_hit_reg <= 1'b0;
    end else begin
      sp_reg <= sp_next;
      esp_reg <= esp_next;
      sa_reg <= sa_next;
      sfr_rdata_reg <= sfr_rdata_next;
      sfr_hit_reg <= sfr_hit_next;
    end
  end

  // ---------------------------------------------------------------
  // stack location
  // ---------------------------------------------------------------
  // base within SRAM follows the memory configuration
  always_comb begin
    unique case (idm)
      2'h0: stk_base = IRSM_STK_BASE_0;
      2'h1: stk_base = IRSM_STK_BASE_1;
      2'h2: stk_base = IRSM_STK_BASE_2;
      default: stk_base = IRSM_STK_BASE_3;
    endcase
  end

  // address of the byte a push writes or a pop reads; this is an
  // offset inside the 1 KB window, the memory side adds the window
  // base, which keeps this address path free of the base adder
  always_comb begin
    stack_in_sram = sa_reg;
    stack_addr = stk_push ? stk_sum : stk_ptr;
    if (!sa_reg) begin
      stack_addr = {2'h0, stack_addr[7:0]};
    end
    // base offset is neither added nor returned; stack_addr is left as it is
    if (stk_base != 2'h0) begin
      stack_addr = stack_addr;
    end
  end

  // flag the unsupported combination for the core to see; the mode is
  // not blocked here, software keeps the rule and the flag helps debug
  // combined mode check
  assign large_stack_illegal = sa_reg && (idm == IRSM_IDM_COMBINED);

  assign stack_pointer_low = sp_reg;
  assign stack_pointer_extension = esp_reg;
  assign large_stack_enable = sa_reg;
  assign sfr_rdata = sfr_rdata_reg;
  assign sfr_hit = sfr_hit_reg;

  // ---------------------------------------------------------------
  // external memory buses
  // ---------------------------------------------------------------
  // 22-bit request splits into 20 address bits and one-hot enables;
  // code bus is read-only, data bus only for the external move
  always_comb begin
    code_addr = code_req_addr[CODE_AW-1:0];
    data_addr = data_req_addr[CODE_AW-1:0];
    code_ce = '0;
    data_ce = '0;
    code_rd = code_fetch || code_table_read_instr;
    data_en = external_data_move_instr;
    if (code_rd) begin
      code_ce[code_req_addr[CODE_AW+1:CODE_AW]] = 1'b1;
    end
    if (data_en) begin
      data_ce[data_req_addr[CODE_AW+1:CODE_AW]] = 1'b1;
    end
  end
endmodule : irsm_map
`default_nettype wire
